/* hdl/acp_ctrl.sv */
// Converter control: calibration sequencing, power-down gating,
// demultiplexed output words, output clock and out-of-range flag.
// Assumes the conversion datapath presents a result on i_conv in the
// system clock domain, valid at each sample clock falling edge.
// The sample clock must hold each level for three system cycles
// or more; shorter levels are lost in the synchronisers.
// Calibration length is a fixed count of sample cycles.
module acp_ctrl
    import acp_pkg::*;
#(
    parameter logic [30:0] PWRUP_DLY_SHORT = DLY_SHORT_DFLT, // Short delay
    parameter logic [30:0] PWRUP_DLY_LONG = DLY_LONG_DFLT,   // Long delay
    parameter logic [30:0] CAL_RUN_CYC = CAL_RUN_DFLT        // Cal length
) (
    input wire logic i_clk,                 // System clock
    input wire logic i_sys_rst,             // Async reset, high
    input wire logic i_sample_clk,          // Sample clock pin
    input wire logic i_range_select,        // Full-scale range pin
    input wire logic i_cal_delay_select,    // Power-up delay pin
    input wire logic i_cal_req,             // Calibration request pin
    input wire logic i_power_down_in,       // Power-down pin
    input wire logic i_edge_select,         // Output edge pin
    input wire acp_conv_t i_conv,           // Datapath result
    output logic [7:0] o_bus_a,             // Odd-edge word bus
    output logic [7:0] o_bus_b,             // Even-edge word bus
    output logic o_output_clock,            // Forwarded data clock
    output logic o_oor_p,                   // Out-of-range, positive
    output logic o_oor_n,                   // Out-of-range, negative
    output logic o_out_oe,                  // Digital output enable
    output logic o_cal_active,              // Calibration running
    output logic o_cal_start,               // Cal start pulse
    output logic o_analog_pd,               // Analog power-down
    output logic o_range_high               // 800 mV range selected
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;              // All async pins
    logic [PIN_W-1:0] pin_meta_r;           // First stage, only stage two
    logic [PIN_W-1:0] pin_sync_r;           // Second stage, safe to use

    // Lane order follows the PIN_ indices
    assign pin_raw = {i_sample_clk, i_edge_select, i_power_down_in,
                      i_cal_req, i_cal_delay_select, i_range_select};

    // Two flops per pin lane; the first stage gets a full cycle
    // to settle before anything reads the lane
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    pin_meta_r[gi] <= PIN_RST[gi];
                    pin_sync_r[gi] <= PIN_RST[gi];
                end else begin
                    pin_meta_r[gi] <= pin_raw[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    // Settled levels, two to three cycles behind the pins
    wire range_s = pin_sync_r[PIN_RANGE];   // Range select level
    wire cal_delay_select_s = pin_sync_r[PIN_CAL_DELAY_SELECT]; // Delay select level
    wire cal_s = pin_sync_r[PIN_CAL];       // Request level
    wire pd_s = pin_sync_r[PIN_PD];         // Power-down level
    wire edge_s = pin_sync_r[PIN_EDGE];     // Edge select level
    wire sclk_s = pin_sync_r[PIN_SCLK];     // Sample clock level

    // ------------------------------------------------------------
    // Sample clock edges and presence
    // ------------------------------------------------------------
    logic sclk_d_r;                         // Delayed sample clock
    logic [7:0] loss_cnt_r;                 // Cycles since last edge
    logic clk_run_r;                        // Sample clock alive

    // Edges seen in the same cycle that the settled level moves
    wire sclk_rise = sclk_s & ~sclk_d_r;    // One sample cycle elapsed
    wire sclk_fall = ~sclk_s & sclk_d_r;    // Conversion start edge
    wire sclk_edge = sclk_rise | sclk_fall; // Any activity

    // Edge detect register; reset low like the synchroniser,
    // so no false fall follows reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sclk_d_r <= 1'h0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    // Loss detector: no edge for the loss time means clock stopped
    // The power-on sequence keeps analog off while this is low
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            loss_cnt_r <= 8'h00;
            clk_run_r <= 1'h0;
        end else if (sclk_edge) begin
            // Any edge restarts the timeout
            loss_cnt_r <= 8'h00;
            clk_run_r <= 1'h1;
        end else if (loss_cnt_r == CLK_LOSS_CNT) begin
            // Park at the limit until the next edge
            clk_run_r <= 1'h0;
        end else begin
            loss_cnt_r <= loss_cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    // One counter serves the delay and then the calibration
    acp_state_t state_r;                    // Sequencer state
    acp_state_t state_nxt;
    logic [30:0] cnt_r;                     // Delay / calibration counter
    logic [30:0] cnt_nxt;
    logic [1:0] boot_r;                     // Boot settle counter
    logic [3:0] low_cnt_r;                  // Request low run length
    logic [3:0] low_cnt_nxt;
    logic [3:0] high_cnt_r;                 // Request high run length
    logic [3:0] high_cnt_nxt;
    logic pd_eff_r;                         // Power-down in force
    logic cal_go;                           // Entering calibration

    // Counter compares shared by the state machine
    wire boot_done = (boot_r == BOOT_CNT);  // Synchronisers filled
    wire [30:0] dly_target =                // Selected power-up delay
        cal_delay_select_s ? PWRUP_DLY_LONG : PWRUP_DLY_SHORT;
    wire dly_last = (cnt_r == dly_target - 31'h1);
    wire cal_last = (cnt_r == CAL_RUN_CYC - 31'h1);
    wire low_ok = (low_cnt_r == QUAL_CNT);  // Low long enough
    wire high_last = (high_cnt_r == QUAL_CNT - 4'h1);

    // Next-state logic; counts use sample clock cycles throughout,
    // so a late clock only shifts the sequence in time
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        low_cnt_nxt = low_cnt_r;
        high_cnt_nxt = high_cnt_r;
        cal_go = 1'h0;
        case (state_r)
            ST_BOOT: begin
                // Strap: request high skips power-on cal
                // Decided once the synchronisers show the pins
                if (boot_done) begin
                    state_nxt = cal_s ? ST_IDLE : ST_PWRUP;
                    cnt_nxt = 31'h0;
                end
            end
            ST_PWRUP: begin
                // Counter frozen while power-down held
                if (!pd_s && sclk_rise) begin
                    if (dly_last) begin
                        // Delay over, calibrate
                        state_nxt = ST_CAL;
                        cnt_nxt = 31'h0;
                        cal_go = 1'h1;
                    end else begin
                        // One more sample cycle of delay
                        cnt_nxt = cnt_r + 31'h1;
                    end
                end
            end
            ST_CAL: begin
                // Calibration of fixed length
                if (sclk_rise) begin
                    if (cal_last) begin
                        // Last cycle done, back to normal running
                        state_nxt = ST_IDLE;
                        cnt_nxt = 31'h0;
                    end else begin
                        cnt_nxt = cnt_r + 31'h1;
                    end
                end
            end
            ST_IDLE: begin
                if (pd_eff_r) begin
                    // Powered down: forget any request
                    low_cnt_nxt = 4'h0;
                    high_cnt_nxt = 4'h0;
                end else if (sclk_rise) begin
                    if (!cal_s) begin
                        // Low phase, saturating
                        high_cnt_nxt = 4'h0;
                        if (!low_ok) begin
                            low_cnt_nxt = low_cnt_r + 4'h1;
                        end
                    end else if (!low_ok) begin
                        // High too early: restart qualification
                        low_cnt_nxt = 4'h0;
                        high_cnt_nxt = 4'h0;
                    end else if (high_last) begin
                        // Tenth high cycle: start
                        state_nxt = ST_CAL;
                        cnt_nxt = 31'h0;
                        low_cnt_nxt = 4'h0;
                        high_cnt_nxt = 4'h0;
                        cal_go = 1'h1;
                    end else begin
                        // Still qualifying the high level
                        high_cnt_nxt = high_cnt_r + 4'h1;
                    end
                end
            end
            default: begin
                // Unused code: recover through boot
                state_nxt = ST_BOOT;
                cnt_nxt = 31'h0;
            end
        endcase
    end

    // Sequencer registers; counters clear on reset so a reset
    // during qualification forgets the request
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= ST_BOOT;
            cnt_r <= 31'h0;
            low_cnt_r <= 4'h0;
            high_cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            low_cnt_r <= low_cnt_nxt;
            high_cnt_r <= high_cnt_nxt;
        end
    end

    // Boot settle counter
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            boot_r <= 2'h0;
        end else if (!boot_done) begin
            // Stops at the settle count
            boot_r <= boot_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Power-down gating
    // ------------------------------------------------------------
    wire in_cal = (state_r == ST_CAL);      // Calibration in progress
    // Entry deferred during calibration, release immediate. The
    // cycle that starts a calibration counts as calibrating, so a
    // power-down arriving in that cycle cannot cut it off.
    wire cal_busy = in_cal | cal_go;        // Calibrating or starting
    wire pd_eff_nxt = pd_s & (pd_eff_r | ~cal_busy);

    // Registered so the pad enable never glitches
    // Effective power-down register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pd_eff_r <= 1'h0;
        end else begin
            pd_eff_r <= pd_eff_nxt;
        end
    end

    // Power-on sequence active: delay or calibration phase
    // Boot is left out: it lasts only four cycles
    wire pwron_act = (state_r == ST_PWRUP) | in_cal;

    // ------------------------------------------------------------
    // Output demultiplexer and output clock
    // ------------------------------------------------------------
    logic phase_r;                          // High after odd fall
    acp_conv_t stage_a_r;                   // Odd word waiting
    acp_conv_t bus_a_r;                     // Bus A word
    acp_conv_t bus_b_r;                     // Bus B word
    logic oor_r;                            // Pair out of range
    logic output_clock_r;                           // Output clock level

    // Falls while down are dropped, freezing the pair phase
    wire take = sclk_fall & ~pd_eff_r;      // Convert only when powered
    // Either word of the pair clipped
    wire pair_clip = stage_a_r.clip | i_conv.clip;

    // Phase and staging; no edges means nothing moves
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // First fall after reset is an odd fall
            phase_r <= 1'h0;
            stage_a_r <= CONV_RST;
        end else if (take) begin
            // Odd and even falls alternate
            phase_r <= ~phase_r;
            if (!phase_r) begin
                stage_a_r <= i_conv;        // Odd fall
            end
        end
    end

    // Bus words update together on the even fall
    // so one output clock edge latches both buses
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_a_r <= CONV_RST;
            bus_b_r <= CONV_RST;
            oor_r <= 1'h0;
        end else if (take && phase_r) begin
            // Odd word from staging, even word straight in
            bus_a_r <= stage_a_r;
            bus_b_r <= i_conv;
            oor_r <= pair_clip;
        end
    end

    // Output clock: data change lands on the selected edge
    // Odd fall drives the opposite level, so the even fall makes
    // the edge that edge select asks for
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Low until the first fall
            output_clock_r <= 1'h0;
        end else if (take) begin
            output_clock_r <= phase_r ? edge_s : ~edge_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Buses hold their words while the sample clock is stopped
    assign o_bus_a = bus_a_r.code;
    assign o_bus_b = bus_b_r.code;
    assign o_output_clock = output_clock_r;
    assign o_oor_p = oor_r;
    assign o_oor_n = ~oor_r;
    // Enable low means the pads float; the buses keep their last
    // words underneath
    assign o_out_oe = ~pd_eff_r;
    assign o_cal_active = in_cal;
    // Combinational, one cycle wide
    assign o_cal_start = cal_go;
    // Low power when down, or sequence waiting on a dead clock
    assign o_analog_pd = pd_eff_r | (pwron_act & ~clk_run_r);
    assign o_range_high = range_s;

endmodule

/* common/acp_pkg.sv */
// Constants, types and state codes for the converter control block.
// Assumes a single 125 MHz system clock and that every converter pin
// arrives asynchronously and is synchronised inside the block.
package acp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_MHZ = 125;      // System clock rate
    localparam int unsigned CLK_LOSS_NS = 400;      // Sample clock loss time
    localparam int unsigned CLK_LOSS_CYC =
        (CLK_LOSS_NS * SYS_CLK_MHZ) / 1000;         // Longest time, round down
    localparam logic [7:0] CLK_LOSS_CNT = 8'(CLK_LOSS_CYC);
    localparam logic [1:0] BOOT_CNT = 2'h3;         // Synchroniser fill time
    localparam logic [3:0] QUAL_CNT = 4'hA;         // Request level qualify
    localparam logic [30:0] DLY_SHORT_DFLT = 31'h0100_0000; // 2^24 cycles
    localparam logic [30:0] DLY_LONG_DFLT = 31'h4000_0000;  // 2^30 cycles
    localparam logic [30:0] CAL_RUN_DFLT = 31'h0000_0800;   // Cal length

    // ------------------------------------------------------------
    // Pin synchroniser lanes
    // ------------------------------------------------------------
    localparam int unsigned PIN_RANGE = 0;          // Range select
    localparam int unsigned PIN_CAL_DELAY_SELECT = 1;         // Cal delay select
    localparam int unsigned PIN_CAL = 2;            // Cal request
    localparam int unsigned PIN_PD = 3;             // Power-down input
    localparam int unsigned PIN_EDGE = 4;           // Edge select
    localparam int unsigned PIN_SCLK = 5;           // Sample clock
    localparam int unsigned PIN_W = 6;              // Lane count
    localparam logic [PIN_W-1:0] PIN_RST = 6'h00;   // Synchroniser reset

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_BOOT = 3'h0,                             // Waiting on strap
        ST_PWRUP = 3'h1,                            // Power-up delay
        ST_CAL = 3'h2,                              // Calibration running
        ST_IDLE = 3'h3                              // Normal operation
    } acp_state_t;

    typedef struct packed {
        logic clip;                                 // Result clipped
        logic [7:0] code;                           // Conversion code
    } acp_conv_t;

    localparam acp_conv_t CONV_RST = 9'h000;        // Output word reset

endpackage

/* tb/acp_ctrl_asserts.sv */
// Port assertions for the converter control block.
// Assumes one clock domain and the active-high async reset.
module acp_ctrl_chk
    import acp_pkg::*;
(
    input wire logic i_clk,          // System clock
    input wire logic i_sys_rst,      // Reset, high
    input wire logic i_range_select, // Range pin
    input wire logic [7:0] o_bus_a,  // Odd word bus
    input wire logic o_output_clock, // Data clock
    input wire logic o_oor_p,        // Out of range
    input wire logic o_oor_n,        // Out of range, low leg
    input wire logic o_out_oe,       // Output enable
    input wire logic o_cal_active,   // Calibrating
    input wire logic o_cal_start,    // Cal start pulse
    input wire logic o_analog_pd,    // Analog off
    input wire logic o_range_high    // Synced range
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Common clock and reset
    // ------------------------------------------------------------
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_oor_legs: assert property (o_oor_n == !o_oor_p)
        else $error("out-of-range legs agree");
    a_oor_paired: assert property ($changed(o_oor_p)
        |-> $changed(o_output_clock))
        else $error("flag moved off a word update");
    a_range_high: assert property (i_range_select[*3]
        |-> o_range_high)
        else $error("high range not shown");
    a_range_low: assert property (!i_range_select[*3]
        |-> !o_range_high)
        else $error("low range not shown");
    a_start_act: assert property (o_cal_start
        |-> ##[0:1] o_cal_active)
        else $error("start pulse without calibration");
    a_cal_min: assert property ($rose(o_cal_active)
        |-> o_cal_active[*8])
        else $error("calibration flag too short");
    a_cal_ends: assert property ($rose(o_cal_active)
        |-> ##[1:1000] !o_cal_active)
        else $error("calibration never ends");
    a_cal_keeps_oe: assert property (o_cal_active
        |-> o_out_oe)
        else $error("powered down during calibration");
    a_start_powered: assert property (o_cal_start
        |-> o_out_oe)
        else $error("calibration started while down");
    a_off_tristate: assert property (!o_out_oe
        |-> o_analog_pd && !o_cal_active)
        else $error("outputs off but analog on");
    a_bus_edge: assert property ($changed(o_bus_a)
        |-> $changed(o_output_clock))
        else $error("word changed without clock edge");
endmodule

bind acp_ctrl acp_ctrl_chk u_acp_ctrl_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_range_select(i_range_select), .o_bus_a(o_bus_a),
    .o_output_clock(o_output_clock), .o_oor_p(o_oor_p),
    .o_oor_n(o_oor_n), .o_out_oe(o_out_oe),
    .o_cal_active(o_cal_active), .o_cal_start(o_cal_start),
    .o_analog_pd(o_analog_pd), .o_range_high(o_range_high)
);

/* tb/acp_rx_model.sv */
// Receiving logic model: checks word pairs from the converter.
// Assumes incrementing codes, clip flagged when low nibble is 5.
module acp_rx_model
    import acp_pkg::*;
(
    input wire logic i_clk,         // System clock
    input wire logic i_sys_rst,     // Reset, high
    input wire logic [7:0] i_bus_a, // Odd word
    input wire logic [7:0] i_bus_b, // Even word
    input wire logic i_output_clock,        // Forwarded clock
    input wire logic i_oor,         // Out of range
    input wire logic i_oe,          // Outputs driven
    input wire logic i_edge,        // Expected data edge
    output int o_n_ok,              // Words accepted
    output int o_n_bad              // Words rejected
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Pair checking with flush after any break
    // ------------------------------------------------------------
    logic [7:0] a_r = 8'h00; // Last odd word
    int gap_r = 0;           // Cycles since last word
    int skip_r = 2;          // Words still to discard
    int n_ok = 0;            // Good pairs
    int n_bad = 0;           // Bad pairs
    logic good;              // Pair matches expectation
    assign good = (i_bus_b === i_bus_a + 8'h01) && (i_output_clock === i_edge)
        && (i_oor === (i_bus_a[3:0] == 4'h5 || i_bus_b[3:0] == 4'h5));
    assign o_n_ok = n_ok;
    assign o_n_bad = n_bad;

    // Stale pipeline words dropped after reset, stop or power-down
    always @(posedge i_clk) begin
        gap_r <= gap_r + 1;
        if (i_sys_rst || !i_oe) begin
            skip_r <= 2;
        end else if (i_bus_a !== a_r) begin
            a_r <= i_bus_a;
            gap_r <= 0;
            if (gap_r > 40) begin
                skip_r <= 1;
            end else if (skip_r > 0) begin
                skip_r <= skip_r - 1;
            end else if (good) begin
                n_ok <= n_ok + 1;
            end else begin
                n_bad <= n_bad + 1;
            end
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking bench for the converter control block.
// Assumes the bound checker and the receiver model beside it.
module tb
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0;     // System clock
    logic i_sys_rst = 1'b1; // Reset, high
    logic sclk = 1'b0;      // Sample clock
    logic sclk_run = 1'b1;  // Sample clock enable
    logic rng = 1'b0;       // Range pin
    logic dly = 1'b0;       // Delay select pin
    logic req = 1'b0;       // Calibration request pin
    logic pd = 1'b0;        // Power-down pin
    logic edge_sel = 1'b0;  // Edge select pin
    logic [7:0] cnt = 8'h00; // Code source
    logic [7:0] hold_a;     // Word held at stop
    acp_conv_t conv = CONV_RST;
    logic [7:0] bus_a, bus_b;
    logic output_clock, oor_p, oe, cal_act, apd, rng_hi;
    int errors = 0, n_checks = 0, cyc = 0, t, len, n_ok, n_bad;

    always #4 i_clk = ~i_clk; // 125 MHz
    initial begin
        #3;
        forever #40 if (sclk_run) sclk = ~sclk; // 80 ns, free phase
    end
    // Consecutive codes, one per sample fall
    always @(negedge sclk) cnt <= cnt + 8'h01;
    always @(posedge sclk) conv <= {cnt[3:0] == 4'h5, cnt};

    acp_ctrl #(.PWRUP_DLY_SHORT(31'h14), .PWRUP_DLY_LONG(31'h28),
        .CAL_RUN_CYC(31'h10)) u_acp_ctrl (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sample_clk(sclk),
        .i_range_select(rng), .i_cal_delay_select(dly),
        .i_cal_req(req), .i_power_down_in(pd), .i_edge_select(edge_sel),
        .i_conv(conv), .o_bus_a(bus_a), .o_bus_b(bus_b),
        .o_output_clock(output_clock), .o_oor_p(oor_p), .o_oor_n(),
        .o_out_oe(oe), .o_cal_active(cal_act), .o_cal_start(),
        .o_analog_pd(apd), .o_range_high(rng_hi));
    acp_rx_model u_acp_rx_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_bus_a(bus_a), .i_bus_b(bus_b), .i_output_clock(output_clock), .i_oor(oor_p),
        .i_oe(oe), .i_edge(edge_sel), .o_n_ok(n_ok), .o_n_bad(n_bad));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h",
                $time, got, exp);
        end
    endtask
    task automatic chk_win(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h to %0h",
                $time, got, lo, hi);
        end
    endtask
    task automatic do_reset(input logic r, input logic p, input logic d);
        req = r;
        pd = p;
        dly = d;
        i_sys_rst = 1'b1;
        tick(20);
        i_sys_rst = 1'b0;
    endtask
    task automatic wait_cal(input int lim, output int n);
        n = 0;
        while (cal_act !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic wait_end(output int n);
        n = 0;
        while (cal_act === 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
    endtask
    // Request low for lo sample periods, then held high
    task automatic req_go(input int lo);
        req = 1'b0;
        tick(lo * 10);
        req = 1'b1;
    endtask
    task automatic pwr_on(input logic d, input logic late,
        input int lo, input int hi);
        sclk_run = !late;
        do_reset(1'b0, 1'b0, d);
        if (late) begin
            tick(80);
            chk_val(8'(apd), 8'h01);
            sclk_run = 1'b1;
        end
        wait_cal(1000, t);
        chk_win(t, lo, hi);
        wait_end(len);
        chk_win(len, 150, 175);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        pwr_on(1'b0, 1'b1, 180, 230);
        pwr_on(1'b1, 1'b0, 380, 430);
        $display("test power_on done");
        do_reset(1'b1, 1'b0, 1'b0);
        wait_cal(600, t);
        chk_win(t, 600, 600);
        req_go(5);
        wait_cal(250, t);
        chk_win(t, 250, 250);
        req_go(12);
        wait_cal(200, t);
        chk_win(t, 85, 125);
        wait_end(len);
        chk_win(len, 150, 175);
        $display("test command done");
        edge_sel = 1'b1;
        do_reset(1'b0, 1'b1, 1'b0);
        wait_cal(500, t);
        chk_win(t, 500, 500);
        chk_val(8'(oe), 8'h00);
        chk_val(8'(apd), 8'h01);
        pd = 1'b0;
        wait_cal(1000, t);
        chk_win(t, 180, 230);
        wait_end(len);
        chk_win(len, 150, 175);
        req_go(12);
        wait_cal(200, t);
        chk_win(t, 85, 125);
        pd = 1'b1;
        tick(20);
        chk_val(8'(oe), 8'h01);
        wait_end(len);
        chk_win(len, 130, 155);
        tick(10);
        chk_val(8'(oe), 8'h00);
        req_go(12);
        wait_cal(150, t);
        chk_win(t, 150, 150);
        pd = 1'b0;
        wait_cal(300, t);
        chk_win(t, 300, 300);
        $display("test power_down done");
        for (int r = 0; r < 2; r++) begin
            rng = r[0];
            tick(5);
            chk_val(8'(rng_hi), 8'(r));
        end
        sclk_run = 1'b0;
        tick(60);
        hold_a = bus_a;
        tick(200);
        chk_val(bus_a, hold_a);
        chk_win(n_bad, 0, 0);
        chk_win(n_ok, 20, 100000);
        $display("test data done");
        stop_test();
    end
endmodule
